/* rtl/sio_edge_det.sv */
// Rising and falling edge detector for a vector of function levels.
`timescale 1ns/1ps
module sio_edge_det #(
  parameter int W = 6
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Levels and edges.
  input wire logic [W-1:0] level_i,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);

  logic [W-1:0] prev_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= '0;
    end else if (ce) begin
      prev_q <= level_i;
    end
  end

  assign rise_o = level_i & ~prev_q;
  assign fall_o = ~level_i & prev_q;

endmodule : sio_edge_det

/* rtl/sio_function_map.sv */
// Maps programmable input and output pins onto drive functions.
`timescale 1ns/1ps
module sio_function_map #(
  parameter int FAULT_DELAY_CYC = sio_pkg::FAULT_DELAY_CYC
) (
  // Clock, reset and clock enable.
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Input pins and their function codes.
  input wire logic [sio_pkg::N_DI-1:0] di_pin,
  input wire logic [sio_pkg::N_DI-1:0][sio_pkg::CODE_W-1:0] di_code,
  // Output pin function codes and active control mode.
  input wire logic [sio_pkg::N_DO-1:0][sio_pkg::CODE_W-1:0] do_code,
  input wire sio_pkg::sio_mode_t ctrl_mode,
  // Drive state from the control core.
  input wire sio_pkg::sio_status_t drive_status,
  // Decoded commands.
  output sio_pkg::sio_ctrl_t ctrl_o,
  output sio_pkg::sio_pulse_t pulse_o,
  output logic limit_switch_alarm,
  // Output pins.
  output logic [sio_pkg::N_DO-1:0] do_pin
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions.

  // Level of a function: OR of every input pin that carries its code.
  function automatic logic fn_level(
    input logic [sio_pkg::N_DI-1:0] pins,
    input logic [sio_pkg::N_DI-1:0][sio_pkg::CODE_W-1:0] codes,
    input logic [5:0] code
  );
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < sio_pkg::N_DI; i++) begin
      hit = hit | (pins[i] & (codes[i] == code));
    end
    return hit;
  endfunction : fn_level

  // Whether any input pin carries a code, whatever its level.
  function automatic logic fn_assigned(
    input logic [sio_pkg::N_DI-1:0][sio_pkg::CODE_W-1:0] codes,
    input logic [5:0] code
  );
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < sio_pkg::N_DI; i++) begin
      hit = hit | (codes[i] == code);
    end
    return hit;
  endfunction : fn_assigned

  // Picks the term that belongs to the active control mode.
  function automatic logic fn_by_mode(
    input sio_pkg::sio_mode_t mode,
    input logic pos_term,
    input logic speed_term,
    input logic torque_term
  );
    logic sel;
    sel = 1'b0;
    unique case (mode)
      sio_pkg::SIO_MODE_POS_EXT, sio_pkg::SIO_MODE_POS_INT: begin
        sel = pos_term;
      end
      sio_pkg::SIO_MODE_SPEED: begin
        sel = speed_term;
      end
      sio_pkg::SIO_MODE_TORQUE: begin
        sel = torque_term;
      end
    endcase
    return sel;
  endfunction : fn_by_mode

  ////////////////////////////////////////////////////////////////////////////
  // Input decode.

  logic [sio_pkg::N_DI-1:0][sio_pkg::CODE_W-1:0] codes;
  logic servo_en;
  logic ccw_cw_in;
  logic cw_ccw_in;
  logic emg_assigned;
  logic emg_level;
  logic fwd_lim;
  logic rev_lim;
  logic [sio_pkg::N_EDGE-1:0] edge_lvl;
  logic [sio_pkg::N_EDGE-1:0] edge_rise;
  logic [sio_pkg::N_EDGE-1:0] edge_fall;
  sio_pkg::sio_ctrl_t ctrl_d;
  sio_pkg::sio_pulse_t pulse_d;

  assign codes = di_code;

  // Unknown codes never match any lookup, so they have no effect.
  assign servo_en = fn_level(di_pin, codes, sio_pkg::DI_SERVO_ENABLE);
  assign ccw_cw_in = fn_level(di_pin, codes,
                              sio_pkg::DI_CCW_SPEED_CW_TORQUE);
  assign cw_ccw_in = fn_level(di_pin, codes,
                              sio_pkg::DI_CW_SPEED_CCW_TORQUE);
  assign emg_assigned = fn_assigned(codes, sio_pkg::DI_EMERGENCY_STOP);
  assign emg_level = fn_level(di_pin, codes, sio_pkg::DI_EMERGENCY_STOP);
  assign fwd_lim = fn_level(di_pin, codes, sio_pkg::DI_FWD_LIMIT);
  assign rev_lim = fn_level(di_pin, codes, sio_pkg::DI_REV_LIMIT);

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection.

  // Edge lanes: error clear, trigger, then the four events.
  always_comb begin
    edge_lvl = '0;
    edge_lvl[sio_pkg::EDGE_CLEAR] =
      fn_level(di_pin, codes, sio_pkg::DI_POS_ERR_CLEAR);
    edge_lvl[sio_pkg::EDGE_TRIGGER] =
      fn_level(di_pin, codes, sio_pkg::DI_POS_TRIGGER);
    for (int e = 0; e < 4; e++) begin
      edge_lvl[sio_pkg::EDGE_EVENT0 + e] =
        fn_level(di_pin, codes, sio_pkg::DI_EVENT_ONE + 6'(e));
    end
  end

  // History clears to zero, so a pin already on when reset is released
  // gives one rising pulse at the first enabled edge.
  sio_edge_det #(
    .W(sio_pkg::N_EDGE)
  ) u_edge (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .level_i(edge_lvl),
    .rise_o(edge_rise),
    .fall_o(edge_fall)
  );

  always_comb begin
    ctrl_d = '0;
    ctrl_d.servo_enable = servo_en;
    ctrl_d.fault_recover =
      fn_level(di_pin, codes, sio_pkg::DI_FAULT_RECOVER);
    ctrl_d.speed_select[0] =
      fn_level(di_pin, codes, sio_pkg::DI_SPEED_SEL0);
    ctrl_d.speed_select[1] =
      fn_level(di_pin, codes, sio_pkg::DI_SPEED_SEL1);
    ctrl_d.speed_select[2] =
      fn_level(di_pin, codes, sio_pkg::DI_SPEED_SEL2);
    // Both directions stay off in the position modes.
    ctrl_d.rotate_ccw =
      fn_by_mode(ctrl_mode, 1'b0, ccw_cw_in, cw_ccw_in);
    ctrl_d.rotate_cw =
      fn_by_mode(ctrl_mode, 1'b0, cw_ccw_in, ccw_cw_in);
    // Active low: a present but released pin holds the stop.
    ctrl_d.emergency_stop = emg_assigned & ~emg_level;
    ctrl_d.position_select[0] =
      fn_level(di_pin, codes, sio_pkg::DI_POS_SEL0);
    ctrl_d.position_select[1] =
      fn_level(di_pin, codes, sio_pkg::DI_POS_SEL1);
    ctrl_d.position_select[2] =
      fn_level(di_pin, codes, sio_pkg::DI_POS_SEL2);
    ctrl_d.position_select[3] =
      fn_level(di_pin, codes, sio_pkg::DI_POS_SEL3);
    ctrl_d.position_select[4] =
      fn_level(di_pin, codes, sio_pkg::DI_POS_SEL4);
    ctrl_d.position_select[5] =
      fn_level(di_pin, codes, sio_pkg::DI_POS_SEL5);
    ctrl_d.hold = fn_level(di_pin, codes, sio_pkg::DI_HOLD) &
                  (ctrl_mode == sio_pkg::SIO_MODE_POS_INT);
    ctrl_d.forward_limit_switch = fwd_lim;
    ctrl_d.reverse_limit_switch = rev_lim;
    ctrl_d.pulse_inhibit =
      fn_level(di_pin, codes, sio_pkg::DI_PULSE_INHIBIT);
    ctrl_d.encoder_count_clear =
      fn_level(di_pin, codes, sio_pkg::DI_ENC_CLEAR);
    ctrl_d.stop = fn_level(di_pin, codes, sio_pkg::DI_STOP);
  end

  always_comb begin
    pulse_d = '0;
    pulse_d.position_error_clear = edge_rise[sio_pkg::EDGE_CLEAR];
    pulse_d.position_command_trigger =
      edge_rise[sio_pkg::EDGE_TRIGGER];
    pulse_d.event_on_edge_command =
      edge_rise[sio_pkg::EDGE_EVENT0 +: 4];
    pulse_d.event_off_edge_command =
      edge_fall[sio_pkg::EDGE_EVENT0 +: 4];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command registers.

  sio_pkg::sio_ctrl_t ctrl_q;
  sio_pkg::sio_pulse_t pulse_q;
  logic limit_alarm_q;

  // Levels toward the control core follow their pins one enabled edge later.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= '0;
    end else if (ce) begin
      ctrl_q <= ctrl_d;
    end
  end

  // Pulses last one enabled cycle.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pulse_q <= '0;
    end else if (ce) begin
      pulse_q <= pulse_d;
    end
  end

  // Limit alarm: a new alarm event wins over a clear in the same cycle.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      limit_alarm_q <= 1'b0;
    end else if (ce) begin
      if (drive_status.limit_alarm_event) begin
        limit_alarm_q <= 1'b1;
      end else if (fwd_lim || rev_lim) begin
        limit_alarm_q <= 1'b0;
      end
    end
  end

  assign ctrl_o = ctrl_q;
  assign pulse_o = pulse_q;
  assign limit_switch_alarm = limit_alarm_q;

  ////////////////////////////////////////////////////////////////////////////
  // Output selection.

  logic delay_done;
  logic in_pos_or_speed;
  logic [sio_pkg::N_DO-1:0] do_d;
  logic [sio_pkg::N_DO-1:0] do_q;

  // The fault output stays off until the power-up delay has run out,
  // whatever the alarm state.
  sio_powerup_timer #(
    .DELAY_CYC(FAULT_DELAY_CYC)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .done_o(delay_done)
  );

  assign in_pos_or_speed = fn_by_mode(ctrl_mode, drive_status.in_position,
                                      drive_status.speed_attained, 1'b0);

  always_comb begin
    do_d = '0;
    for (int p = 0; p < sio_pkg::N_DO; p++) begin
      unique case (do_code[p])
        sio_pkg::DO_READY: begin
          do_d[p] = servo_en & drive_status.ready;
        end
        sio_pkg::DO_FAULT: begin
          do_d[p] = delay_done & ~drive_status.alarm;
        end
        sio_pkg::DO_INPOS_SPEED_OK: begin
          do_d[p] = in_pos_or_speed;
        end
        sio_pkg::DO_LIMIT_REACHED: begin
          do_d[p] = servo_en &
                    fn_by_mode(ctrl_mode, 1'b0, drive_status.torque_at_limit,
                               drive_status.speed_at_limit);
        end
        sio_pkg::DO_CMD_DONE: begin
          do_d[p] = drive_status.command_done;
        end
        sio_pkg::DO_MOTION_DONE: begin
          do_d[p] = drive_status.command_done &
                    drive_status.in_position;
        end
        sio_pkg::DO_SOFT_POS_LIMIT: begin
          do_d[p] = drive_status.soft_pos_limit;
        end
        sio_pkg::DO_SOFT_NEG_LIMIT: begin
          do_d[p] = drive_status.soft_neg_limit;
        end
        default: begin
          do_d[p] = 1'b0;
        end
      endcase
    end
  end

  // Registered pins cannot glitch while codes or drive status change.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      do_q <= '0;
    end else if (ce) begin
      do_q <= do_d;
    end
  end

  assign do_pin = do_q;

endmodule : sio_function_map

/* rtl/sio_pkg.sv */
// Package of codes, constants and carrier types for the servo I/O function map.
//
// Contract
// - Input code 01 is servo enable; motor held excited while active.
// - Input code 02 is fault recovery; returns drive from fault to normal.
// - Input codes 06, 07, 08 form speed select bits for preset speed.
// - Code 09: CCW in speed mode, CW in torque mode while active.
// - Code 0A: CW in speed mode, CCW in torque mode while active.
// - Code 0F clears position pulse error on rising edge only.
// - Code 12 active low: off forces emergency stop, on clears it.
// - Codes 13, 14, 15, 1A, 1B, 1C are six position select bits.
// - Code 16 trigger executes the selected internal position command.
// - Code 17 halts motion while active, only in internal position mode.
// - Codes 18, 19 are limit switches; asserting clears the limit alarm.
// - Code 1D blocks external position pulse command while active.
// - Codes 1E to 21 are four events; each edge starts a command.
// - Code 23 resets absolute encoder pulse count to zero.
// - Code 24 stops motor motion when asserted.
// - Output code 01 on once drive enabled and ready.
// - Output code 02 off on alarm, else on one second after power-up.
// - Output code 03: in position or speed attained, by mode.
// - Output code 05: torque or speed limit by mode, off without enable.
// - Output code 09 on when internal position command done or stopped.
// - Output code 0B is command done AND in position.
// - Output codes 0D, 0E are software positive and negative limits.
package sio_pkg;

  // Pin counts and code width.
  localparam int N_DI = 12;
  localparam int N_DO = 6;
  localparam int CODE_W = 6;
  localparam int N_EDGE = 6;

  // Input function codes.
  localparam logic [5:0] DI_SERVO_ENABLE = 6'h01;
  localparam logic [5:0] DI_FAULT_RECOVER = 6'h02;
  localparam logic [5:0] DI_SPEED_SEL0 = 6'h06;
  localparam logic [5:0] DI_SPEED_SEL1 = 6'h07;
  localparam logic [5:0] DI_SPEED_SEL2 = 6'h08;
  localparam logic [5:0] DI_CCW_SPEED_CW_TORQUE = 6'h09;
  localparam logic [5:0] DI_CW_SPEED_CCW_TORQUE = 6'h0A;
  localparam logic [5:0] DI_POS_ERR_CLEAR = 6'h0F;
  localparam logic [5:0] DI_EMERGENCY_STOP = 6'h12;
  localparam logic [5:0] DI_POS_SEL0 = 6'h13;
  localparam logic [5:0] DI_POS_SEL1 = 6'h14;
  localparam logic [5:0] DI_POS_SEL2 = 6'h15;
  localparam logic [5:0] DI_POS_TRIGGER = 6'h16;
  localparam logic [5:0] DI_HOLD = 6'h17;
  localparam logic [5:0] DI_FWD_LIMIT = 6'h18;
  localparam logic [5:0] DI_REV_LIMIT = 6'h19;
  localparam logic [5:0] DI_POS_SEL3 = 6'h1A;
  localparam logic [5:0] DI_POS_SEL4 = 6'h1B;
  localparam logic [5:0] DI_POS_SEL5 = 6'h1C;
  localparam logic [5:0] DI_PULSE_INHIBIT = 6'h1D;
  localparam logic [5:0] DI_EVENT_ONE = 6'h1E;
  localparam logic [5:0] DI_ENC_CLEAR = 6'h23;
  localparam logic [5:0] DI_STOP = 6'h24;

  // Output function codes.
  localparam logic [5:0] DO_READY = 6'h01;
  localparam logic [5:0] DO_FAULT = 6'h02;
  localparam logic [5:0] DO_INPOS_SPEED_OK = 6'h03;
  localparam logic [5:0] DO_LIMIT_REACHED = 6'h05;
  localparam logic [5:0] DO_CMD_DONE = 6'h09;
  localparam logic [5:0] DO_MOTION_DONE = 6'h0B;
  localparam logic [5:0] DO_SOFT_POS_LIMIT = 6'h0D;
  localparam logic [5:0] DO_SOFT_NEG_LIMIT = 6'h0E;

  // Edge detector lanes.
  localparam int EDGE_CLEAR = 0;
  localparam int EDGE_TRIGGER = 1;
  localparam int EDGE_EVENT0 = 2;

  // Power-up fault output delay.
  localparam longint CLK_FREQ_HZ = 100_000_000;
  localparam longint FAULT_DELAY_MS = 1000;
  localparam int FAULT_DELAY_CYC =
    int'((FAULT_DELAY_MS * CLK_FREQ_HZ) / 1000);
  localparam int TIMER_W = 27;
  localparam logic [TIMER_W-1:0] TIMER_RST = 27'h0000000;

  typedef enum logic [1:0] {
    SIO_MODE_POS_EXT,
    SIO_MODE_POS_INT,
    SIO_MODE_SPEED,
    SIO_MODE_TORQUE
  } sio_mode_t;

  // Drive state reported by the control core.
  typedef struct packed {
    logic alarm;
    logic ready;
    logic in_position;
    logic speed_attained;
    logic torque_at_limit;
    logic speed_at_limit;
    logic command_done;
    logic soft_pos_limit;
    logic soft_neg_limit;
    logic limit_alarm_event;
  } sio_status_t;

  // Decoded commands toward the control core.
  typedef struct packed {
    logic servo_enable;
    logic fault_recover;
    logic [2:0] speed_select;
    logic rotate_ccw;
    logic rotate_cw;
    logic emergency_stop;
    logic [5:0] position_select;
    logic hold;
    logic forward_limit_switch;
    logic reverse_limit_switch;
    logic pulse_inhibit;
    logic encoder_count_clear;
    logic stop;
  } sio_ctrl_t;

  // One-cycle command pulses.
  typedef struct packed {
    logic position_error_clear;
    logic position_command_trigger;
    logic [3:0] event_on_edge_command;
    logic [3:0] event_off_edge_command;
  } sio_pulse_t;

endpackage : sio_pkg

/* rtl/sio_powerup_timer.sv */
// Counts a fixed delay after reset release and then holds a done level.
`timescale 1ns/1ps
module sio_powerup_timer #(
  parameter int DELAY_CYC = sio_pkg::FAULT_DELAY_CYC
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Status.
  output logic done_o
);

  localparam logic [sio_pkg::TIMER_W-1:0] LAST =
    sio_pkg::TIMER_W'(DELAY_CYC - 1);

  logic [sio_pkg::TIMER_W-1:0] count_q;
  logic done_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= sio_pkg::TIMER_RST;
    end else if (ce && !done_q) begin
      count_q <= count_q + sio_pkg::TIMER_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else if (ce && count_q == LAST) begin
      done_q <= 1'b1;
    end
  end

  assign done_o = done_q;

endmodule : sio_powerup_timer

/* verification/sio_drive_model.sv */
// Behavioural control core that answers the map with drive status.
`timescale 1ns/1ps
module sio_drive_model (
  // Commands from the map and status set by the bench.
  input wire sio_pkg::sio_ctrl_t ctrl_o,
  input wire sio_pkg::sio_status_t stat_req,
  // Status toward the map.
  output sio_pkg::sio_status_t drive_status
);
  always_comb begin
    drive_status = stat_req;
    drive_status.ready = ctrl_o.servo_enable & ~stat_req.alarm;
  end
endmodule : sio_drive_model

/* verification/sio_function_map_properties.sv */
// Checker of the function map port behaviour.
`timescale 1ns/1ps
module sio_function_map_properties #(
  parameter int FAULT_DELAY_CYC = 20
) (
  // Clock, reset and enable.
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Pins, codes, mode and status.
  input wire logic [sio_pkg::N_DI-1:0] di_pin,
  input wire logic [sio_pkg::N_DI-1:0][sio_pkg::CODE_W-1:0] di_code,
  input wire logic [sio_pkg::N_DO-1:0][sio_pkg::CODE_W-1:0] do_code,
  input wire sio_pkg::sio_mode_t ctrl_mode,
  input wire sio_pkg::sio_status_t drive_status,
  // Results.
  input wire sio_pkg::sio_ctrl_t ctrl_o,
  input wire sio_pkg::sio_pulse_t pulse_o,
  input wire logic limit_switch_alarm,
  input wire logic [sio_pkg::N_DO-1:0] do_pin
);
  logic [63:0] on_v;
  logic [63:0] has_v;
  logic [31:0] en_cnt_q;
  // Per code: some pin carries it, and the OR of those pins.
  always_comb begin
    on_v = '0;
    has_v = '0;
    for (int i = 0; i < sio_pkg::N_DI; i++) begin
      has_v[di_code[i]] = 1'b1;
      on_v[di_code[i]] = on_v[di_code[i]] | di_pin[i];
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      en_cnt_q <= '0;
    end else if (ce && en_cnt_q < 32'hFFFFFFFF) begin
      en_cnt_q <= en_cnt_q + 32'h1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence clr_pulse;
    pulse_o.position_error_clear ##1 !pulse_o.position_error_clear;
  endsequence
  chk_enable_follow:
    assert property (ce |=> ctrl_o.servo_enable == $past(on_v[1]))
    else $error("Servo enable does not follow its pin.");
  chk_recover_follow:
    assert property (ce |=> ctrl_o.fault_recover == $past(on_v[2]))
    else $error("Fault recovery does not follow its pin.");
  chk_speed_bits:
    assert property (ce |=> ctrl_o.speed_select ==
      $past({on_v[8], on_v[7], on_v[6]}))
    else $error("Speed select bits are wrong.");
  chk_speed_direction:
    assert property (ce && ctrl_mode == sio_pkg::SIO_MODE_SPEED |=>
      ctrl_o.rotate_ccw == $past(on_v[9]) &&
      ctrl_o.rotate_cw == $past(on_v[10]))
    else $error("Speed mode direction is wrong.");
  chk_clear_edge:
    assert property (ce && $past(ce) && on_v[15] && !$past(on_v[15]) ##1 ce
      |-> clr_pulse)
    else $error("Error clear is not a single pulse on the rise.");
  chk_clear_cause:
    assert property ($rose(pulse_o.position_error_clear) |-> $past(on_v[15]))
    else $error("Error clear pulse without its pin on.");
  chk_estop_low:
    assert property (ce |=> ctrl_o.emergency_stop ==
      $past(has_v[6'h12] && !on_v[6'h12]))
    else $error("Emergency stop does not follow its low pin.");
  chk_hold_mode:
    assert property (ctrl_o.hold && $past(ce) |->
      $past(ctrl_mode) == sio_pkg::SIO_MODE_POS_INT)
    else $error("Hold outside internal position mode.");
  chk_limit_set:
    assert property (ce && drive_status.limit_alarm_event |=>
      limit_switch_alarm)
    else $error("Limit alarm not set.");
  chk_limit_clear:
    assert property (ce && !drive_status.limit_alarm_event &&
      (on_v[6'h18] || on_v[6'h19]) |=> !limit_switch_alarm)
    else $error("Limit alarm not cleared by a limit switch.");
  chk_motion_done:
    assert property (ce && do_code[0] == 6'h0B |=> do_pin[0] ==
      $past(drive_status.command_done && drive_status.in_position))
    else $error("Motion complete output is wrong.");
  chk_fault_delay:
    assert property (do_pin[1] && $past(do_code[1]) == 6'h02 |->
      en_cnt_q >= FAULT_DELAY_CYC)
    else $error("Fault output on before the power-up delay.");
  chk_undef_out:
    assert property (ce && do_code[2] == 6'h04 |=> !do_pin[2])
    else $error("Undefined output code drives its pin.");
endmodule : sio_function_map_properties

bind sio_function_map sio_function_map_properties #(
  .FAULT_DELAY_CYC(FAULT_DELAY_CYC)
) u_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .di_pin(di_pin),
  .di_code(di_code), .do_code(do_code), .ctrl_mode(ctrl_mode),
  .drive_status(drive_status), .ctrl_o(ctrl_o), .pulse_o(pulse_o),
  .limit_switch_alarm(limit_switch_alarm), .do_pin(do_pin)
);

/* verification/test_sio_function_map.sv */
// Self-checking bench of the servo I/O function map.
`timescale 1ns/1ps
module test_sio_function_map;
  localparam int DLY = 20;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [11:0] di_pin = '0;
  logic [11:0][5:0] di_code;
  logic [5:0][5:0] do_code;
  logic [5:0][5:0] set_a = {6'h01, 6'h09, 6'h05, 6'h03, 6'h02, 6'h0B};
  logic [5:0][5:0] set_b = {6'h05, 6'h03, 6'h0F, 6'h04, 6'h0E, 6'h0D};
  logic [5:0][5:0] pos_c = {6'h1C, 6'h1B, 6'h1A, 6'h15, 6'h14, 6'h13};
  logic [3:0][5:0] lvl_c = {6'h24, 6'h23, 6'h1D, 6'h17};
  logic [5:0][9:0] st_tab = {10'h016, 10'h064, 10'h080, 10'h208,
    10'h1FE, 10'h000};
  sio_pkg::sio_mode_t ctrl_mode = sio_pkg::SIO_MODE_SPEED;
  sio_pkg::sio_status_t stat_req = '0;
  sio_pkg::sio_status_t drive_status;
  sio_pkg::sio_ctrl_t ctrl_o;
  sio_pkg::sio_pulse_t pulse_o;
  logic limit_switch_alarm;
  logic [5:0] do_pin;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;

  always #5 clk_sys = ~clk_sys;

  sio_function_map #(.FAULT_DELAY_CYC(DLY)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .di_pin(di_pin),
    .di_code(di_code), .do_code(do_code), .ctrl_mode(ctrl_mode),
    .drive_status(drive_status), .ctrl_o(ctrl_o), .pulse_o(pulse_o),
    .limit_switch_alarm(limit_switch_alarm), .do_pin(do_pin));
  sio_drive_model u_model (.ctrl_o(ctrl_o), .stat_req(stat_req),
    .drive_status(drive_status));

  ////////////////////////////////////////////////////////////////////////
  task automatic step(input int n = 1);
    repeat (n) @(negedge clk_sys);
  endtask : step

  task automatic pin(input int i, input logic v);
    di_pin[i] = v;
    step();
  endtask : pin

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
    input string what);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  // Expected output pin level for a code, with servo enable on.
  function automatic logic exp_do(input logic [5:0] c,
    input sio_pkg::sio_status_t s, input sio_pkg::sio_mode_t m);
    logic sp;
    logic tq;
    sp = m == sio_pkg::SIO_MODE_SPEED;
    tq = m == sio_pkg::SIO_MODE_TORQUE;
    case (c)
      6'h01: exp_do = ~s.alarm;
      6'h02: exp_do = ~s.alarm;
      6'h03: exp_do = sp ? s.speed_attained : !tq && s.in_position;
      6'h05: exp_do = sp & s.torque_at_limit | tq & s.speed_at_limit;
      6'h09: exp_do = s.command_done;
      6'h0B: exp_do = s.command_done & s.in_position;
      6'h0D: exp_do = s.soft_pos_limit;
      6'h0E: exp_do = s.soft_neg_limit;
      default: exp_do = 1'b0;
    endcase
  endfunction : exp_do

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    di_code = {6'h18, 6'h1E, 6'h16, 6'h12, 6'h0F, 6'h0A, 6'h09, 6'h08,
      6'h07, 6'h06, 6'h02, 6'h01};
    do_code = set_a;
    step(5);
    rst_n = 1'b1;
    step(2);
    chk(ctrl_o.emergency_stop, 1'b1, "estop");
    chk(do_pin[1], 1'b0, "fault early");
    pin(8, 1'b1);
    chk(ctrl_o.emergency_stop, 1'b0, "estop off");
    pin(0, 1'b1);
    chk(ctrl_o.servo_enable, 1'b1, "enable");
    pin(1, 1'b1);
    chk(ctrl_o.fault_recover, 1'b1, "recover");
    di_pin[4:2] = 3'b101;
    step();
    chk(ctrl_o.speed_select, 3'h5, "speed sel");
    pin(5, 1'b1);
    chk({ctrl_o.rotate_ccw, ctrl_o.rotate_cw}, 2'h2, "ccw speed");
    ctrl_mode = sio_pkg::SIO_MODE_TORQUE;
    step();
    chk({ctrl_o.rotate_ccw, ctrl_o.rotate_cw}, 2'h1, "cw torque");
    pin(5, 1'b0);
    pin(6, 1'b1);
    chk({ctrl_o.rotate_ccw, ctrl_o.rotate_cw}, 2'h2, "ccw torque");
    ctrl_mode = sio_pkg::SIO_MODE_SPEED;
    step();
    chk({ctrl_o.rotate_ccw, ctrl_o.rotate_cw}, 2'h1, "cw speed");
    pin(6, 1'b0);
    pin(7, 1'b1);
    chk(pulse_o.position_error_clear, 1'b1, "clear rise");
    step();
    chk(pulse_o.position_error_clear, 1'b0, "clear level");
    pin(7, 1'b0);
    chk(pulse_o.position_error_clear, 1'b0, "clear fall");
    pin(9, 1'b1);
    chk(pulse_o.position_command_trigger, 1'b1, "trigger");
    pin(9, 1'b0);
    ce = 1'b0;
    pin(0, 1'b0);
    chk(ctrl_o.servo_enable, 1'b1, "frozen");
    ce = 1'b1;
    step();
    chk(ctrl_o.servo_enable, 1'b0, "enable off");
    pin(0, 1'b1);
    for (int k = 0; k < 6; k++) begin
      di_code[9] = pos_c[k];
      pin(9, 1'b1);
      chk(ctrl_o.position_select, 16'(1 << k), "pos sel");
      pin(9, 1'b0);
    end
    ctrl_mode = sio_pkg::SIO_MODE_POS_INT;
    for (int k = 0; k < 4; k++) begin
      di_code[9] = lvl_c[k];
      pin(9, 1'b1);
      chk({ctrl_o.hold, ctrl_o.pulse_inhibit, ctrl_o.encoder_count_clear,
        ctrl_o.stop}, 16'(8 >> k), "level fn");
      pin(9, 1'b0);
    end
    ctrl_mode = sio_pkg::SIO_MODE_POS_EXT;
    di_code[9] = 6'h17;
    pin(9, 1'b1);
    chk(ctrl_o.hold, 1'b0, "hold ext");
    for (int k = 0; k < 2; k++) begin
      ctrl_mode = sio_pkg::SIO_MODE_POS_INT;
      di_code[9] = k ? 6'h22 : 6'h03;
      pin(9, 1'b1);
      chk({pulse_o, ctrl_o.position_select}, 16'h0, "undef");
      chk(ctrl_o.hold, 1'b0, "undef hold");
    end
    pin(9, 1'b0);
    for (int k = 0; k < 4; k++) begin
      di_code[10] = 6'h1E + 6'(k);
      pin(10, 1'b1);
      chk(pulse_o.event_on_edge_command, 16'(1 << k), "ev on");
      pin(10, 1'b0);
      chk(pulse_o.event_off_edge_command, 16'(1 << k), "ev off");
    end
    for (int k = 0; k < 2; k++) begin
      di_code[11] = k ? 6'h19 : 6'h18;
      stat_req.limit_alarm_event = 1'b1;
      step();
      stat_req.limit_alarm_event = 1'b0;
      step();
      chk(limit_switch_alarm, 1'b1, "limit set");
      pin(11, 1'b1);
      chk(limit_switch_alarm, 1'b0, "limit clear");
      chk({ctrl_o.forward_limit_switch, ctrl_o.reverse_limit_switch},
        k ? 16'h1 : 16'h2, "limit pin");
      stat_req.limit_alarm_event = 1'b1;
      step();
      chk(limit_switch_alarm, 1'b1, "limit set wins");
      stat_req.limit_alarm_event = 1'b0;
      pin(11, 1'b0);
    end
    for (int t = 0; t < 2; t++) begin
      do_code = t ? set_b : set_a;
      for (int m = 0; m < 4; m++) begin
        ctrl_mode = sio_pkg::sio_mode_t'(m);
        for (int s = 0; s < 6; s++) begin
          stat_req = st_tab[s];
          step();
          for (int j = 0; j < 6; j++) begin
            chk(do_pin[j], exp_do(do_code[j], stat_req, ctrl_mode),
              "out pin");
          end
        end
      end
    end
    do_code = set_a;
    ctrl_mode = sio_pkg::SIO_MODE_SPEED;
    stat_req = 10'h020;
    pin(0, 1'b0);
    chk(do_pin[3], 1'b0, "limit no enable");
    complete_run();
  end
endmodule : test_sio_function_map
